// [test_uart_nine_bit_break_fifo.sv]
// Self-checking bench for the nine-bit UART
`timescale 1ns/100ps
`default_nettype none
module test_uart_nine_bit_break_fifo;
  import unb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc_tick = 1'b0;
  logic [2:0] oc = '0;
  logic [31:0] rdata;
  logic rxd;
  logic txd;
  logic dma_tx_req;
  logic dma_rx_req;
  logic irq;
  int errors = 0;
  int checked = 0;
  int seed = 89;
  logic [31:0] r;
  logic [7:0] b;
  logic [7:0] own;
  logic [7:0] x;
  logic [7:0] m;
  logic e;
  logic [8:0] q[$];

  always #4 clk = ~clk;
  // Slow oscillator stand-in, one rising edge every 8 clocks
  always @(posedge clk) begin
    oc <= oc + 3'h1;
    osc_tick <= oc[2];
  end

  unb_uart #(.DEPTH(4)) DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .osc_tick(osc_tick), .rxd(rxd), .txd(txd),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq));
  unb_node node (.clk(clk), .txd(txd), .rxd(rxd));

  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] s);
    checked++;
    if (s !== ex) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Strobes move on an edge; the trailing delay lets callers see settled outputs
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic waitst(input int bn, input logic v);
    int n;
    n = 0;
    rreg(REG_STAT, r);
    while (r[bn] !== v && n < 3000) begin
      rreg(REG_STAT, r);
      n++;
    end
    if (r[bn] !== v) begin
      chk("stat_wait", 32'(v), r);
      final_report();
    end
  endtask

  function automatic logic hit(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] c);
    return (c & mk) == (a & mk);
  endfunction

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(REG_CTRL, r);
    chk("ctrl_rst", 32'h0000_0000, r);
    rreg(REG_ADDR, r);
    chk("addr_rst", 32'h0000_ff00, r);
    rreg(REG_BAUD, r);
    chk("baud_rst", 32'h0000_0043, r);
    rreg(REG_STAT, r);
    chk("stat_rst", 32'h0000_0008, r);
    rreg(6'h3C, r);
    chk("unmapped", 32'h0000_0000, r);
    wreg(REG_BAUD, 32'h0000_0000);
    wreg(REG_CTRL, 32'h0000_0001);
    // Normal mode, back-to-back writes with random bytes
    q = {};
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      q.push_back({1'b0, b});
      wreg(REG_DATA, 32'(b));
    end
    rreg(REG_STAT, r);
    chk("busy_on", 32'h1, 32'(r[ST_BUSY]));
    waitst(ST_BUSY, 1'b0);
    chk("tx_count", 32'd3, 32'(node.got.size()));
    for (int i = 0; i < 3; i++) begin
      chk("tx_char", 32'(q[i]), 32'(node.got[i]));
    end
    chk("irq_masked", 32'h0, 32'(irq));
    wreg(REG_IMSK, 32'h0000_0002);
    chk("irq_on", 32'h1, 32'(irq));
    rreg(REG_MIS, r);
    chk("mis", 32'h0000_0002, r & 32'h0000_0002);
    wreg(REG_RIS, 32'h0000_0002);
    chk("irq_clr", 32'h0, 32'(irq));
    // Nine-bit transmit: address, then data, idle around the address
    node.got.delete();
    node.nbits = 9;
    wreg(REG_CTRL, 32'h0000_0003);
    own = 8'($random(seed));
    b = 8'($random(seed));
    waitst(ST_BUSY, 1'b0);
    wreg(REG_ADSEND, 32'(own));
    waitst(ST_BUSY, 1'b0);
    wreg(REG_DATA, 32'(b));
    waitst(ST_BUSY, 1'b0);
    chk("adr_char", 32'({1'b1, own}), 32'(node.got[0]));
    chk("dat_char", 32'({1'b0, b}), 32'(node.got[1]));
    // Nine-bit receive matching, exact and set masks
    wreg(REG_CTRL, 32'h0000_0023);
    for (int k = 0; k < 2; k++) begin
      m = (k == 0) ? 8'hff : 8'hf0;
      wreg(REG_ADDR, 32'({m, own}));
      for (int j = 0; j < 3; j++) begin
        x = (j == 0) ? own : ((j == 1) ? (own ^ 8'h01) : (own ^ 8'h80));
        b = 8'($random(seed));
        e = hit(own, m, x);
        node.send({1'b1, x});
        node.send({1'b0, b});
        rreg(REG_STAT, r);
        chk("rx_avail", 32'(e), 32'(r[ST_RX_AVAIL]));
        chk("dma_rx", 32'(e), 32'(dma_rx_req));
        rreg(REG_DATA, r);
        chk("rx_data", e ? 32'(b) : 32'h0, r);
        rreg(REG_DATA, r);
        chk("rx_empty", 32'h0, r);
      end
    end
    // Normal mode receive raises the rx event
    node.nbits = 8;
    wreg(REG_CTRL, 32'h0000_0001);
    wreg(REG_RIS, 32'h0000_000f);
    wreg(REG_IMSK, 32'h0000_0001);
    b = 8'($random(seed));
    node.send({1'b0, b});
    chk("irq_rx", 32'h1, 32'(irq));
    rreg(REG_DATA, r);
    chk("rx_norm", 32'(b), r);
    wreg(REG_RIS, 32'h0000_0001);
    chk("irq_rx_clr", 32'h0, 32'(irq));
    // Overfill on purpose, then disable in mid-frame
    node.got.delete();
    wreg(REG_CTRL, 32'h0000_0011);
    chk("dma_tx", 32'h1, 32'(dma_tx_req));
    q = {};
    for (int i = 0; i < 6; i++) begin
      b = 8'($random(seed));
      q.push_back({1'b0, b});
      wreg(REG_DATA, 32'(b));
    end
    rreg(REG_STAT, r);
    chk("tx_full", 32'h1, 32'(r[ST_TX_FULL]));
    chk("dma_tx_full", 32'h0, 32'(dma_tx_req));
    wreg(REG_CTRL, 32'h0000_0000);
    waitst(ST_BUSY, 1'b0);
    chk("dis_count", 32'd1, 32'(node.got.size()));
    chk("dis_char", 32'(q[0]), 32'(node.got[0]));
    chk("dis_empty", 32'h1, 32'(r[ST_TX_EMPTY]));
    // Break held for two frames, then released
    wreg(REG_CTRL, 32'h0000_0005);
    repeat (2) begin
      repeat (176) @(posedge clk);
      chk("break_low", 32'h0, 32'(txd));
    end
    wreg(REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("break_off", 32'h1, 32'(txd));
    // Oscillator as baud source, baud set again after the switch
    node.got.delete();
    node.bitp = 128;
    wreg(REG_CTRL, 32'h0000_0009);
    wreg(REG_BAUD, 32'h0000_0000);
    rreg(REG_CTRL, r);
    chk("ctrl_src", 32'h0000_0009, r);
    rreg(REG_STAT, r);
    chk("stat_src", 32'h1, 32'(r[ST_SRC]));
    b = 8'($random(seed));
    wreg(REG_DATA, 32'(b));
    waitst(ST_BUSY, 1'b0);
    chk("osc_char", 32'(b), 32'(node.got[0]));
    final_report();
  end
endmodule
`default_nettype wire

// [unb_fifo.sv]
// Flip-flop FIFO used for both transmit and receive queues
`timescale 1ns/100ps
`default_nettype none
module unb_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic empty,
  output logic full
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign rdata = mem_q[rp_q];
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wp_q] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

// [unb_node.sv]
// Remote serial node model: captures frames from txd, sends frames on rxd
`timescale 1ns/100ps
`default_nettype none
module unb_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bitp = 16;
  int nbits = 8;
  logic [8:0] got[$];
  initial rxd = 1'b1;
  // Mid-bit sampling; a frame with a low stop bit (break) is not kept
  always @(negedge txd) begin
    logic [8:0] v;
    v = '0;
    repeat (bitp / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bitp) @(posedge clk);
      v[i] = txd;
    end
    repeat (bitp) @(posedge clk);
    if (txd === 1'b1) begin
      got.push_back(v);
    end
  end
  // Line idles high after each frame so the receiver can re-arm
  task automatic send(input logic [8:0] v);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bitp) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= v[i];
      repeat (bitp) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bitp * 2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [unb_pkg.sv]
// Package: register map, field positions and constants for the nine-bit UART
package unb_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] REG_DATA = 6'h00;
  localparam logic [5:0] REG_STAT = 6'h04;
  localparam logic [5:0] REG_CTRL = 6'h08;
  localparam logic [5:0] REG_ADDR = 6'h0C;
  localparam logic [5:0] REG_ADSEND = 6'h10;
  localparam logic [5:0] REG_BAUD = 6'h14;
  localparam logic [5:0] REG_RIS = 6'h18;
  localparam logic [5:0] REG_IMSK = 6'h1C;
  localparam logic [5:0] REG_MIS = 6'h20;
  // Control bits
  localparam int unsigned CTL_EN = 0;
  localparam int unsigned CTL_NINE = 1;
  localparam int unsigned CTL_BRK = 2;
  localparam int unsigned CTL_SRC = 3;
  localparam int unsigned CTL_DMA_TX = 4;
  localparam int unsigned CTL_DMA_RX = 5;
  localparam int unsigned CTL_W = 6;
  // Status bits
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_RX_AVAIL = 1;
  localparam int unsigned ST_TX_FULL = 2;
  localparam int unsigned ST_TX_EMPTY = 3;
  localparam int unsigned ST_RX_FULL = 4;
  localparam int unsigned ST_SRC = 5;
  // Interrupt bits
  localparam int unsigned IRQ_RX = 0;
  localparam int unsigned IRQ_TX_DONE = 1;
  localparam int unsigned IRQ_OVR = 2;
  localparam int unsigned IRQ_FRAME = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [15:0] BAUD_RST = 16'h0043;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] DBITS_8 = 4'h8;
  localparam logic [3:0] DBITS_9 = 4'h9;
  localparam logic [7:0] MASK_RST = 8'hFF;
endpackage

// [unb_uart.sv]
// Nine-bit multidrop UART with break, busy, FIFOs, DMA requests and interrupts
// Operation
// RULE1 - Address send marks byte as address
// RULE2 - Software waits idle before and after address
// RULE3 - Received address ANDed with mask, compared
// RULE4 - Control bit switches nine-bit mode
// RULE5 - Data FIFO path carries data characters
// RULE6 - Break control holds line low
// RULE7 - Software holds break two frames
// RULE8 - Busy until FIFO empty and stop sent
// RULE9 - Receive-available status bit
// RULE10 - Transmit full status; software writes when space
// RULE11 - Data read pops receive FIFO
// RULE12 - Baud source selectable and readable
// RULE13 - Separately enabled DMA requests
// RULE14 - Interrupts with enable, clear, raw, masked
// RULE15 - Software reprograms baud after source change
// RULE16 - Disable finishes character, flushes transmit FIFO
// RULE17 - Ninth bit one address, zero data
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module unb_uart #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [unb_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic osc_tick,
  input wire logic rxd,
  output logic txd,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic irq
);
  import unb_pkg::*;

  typedef enum logic [1:0] {UNB_IDLE, UNB_START, UNB_BITS, UNB_STOP} unb_st_t;

  logic [CTL_W-1:0] ctrl_q;
  logic [7:0] match_addr_q;
  logic [7:0] match_mask_q;
  logic [15:0] baud_q;
  logic [IRQ_W-1:0] ris_q;
  logic [IRQ_W-1:0] imsk_q;
  logic [31:0] rdata_q;
  // Pin and oscillator synchronisers
  logic rx_s1_q, rx_s2_q, os1_q, os2_q, os3_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      os1_q <= 1'b0;
      os2_q <= 1'b0;
      os3_q <= 1'b0;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
      os1_q <= osc_tick;
      os2_q <= os1_q;
      os3_q <= os2_q;
    end
  end
  // Baud source: system clock or rising edges of the oscillator
  logic src_tick;
  assign src_tick = ctrl_q[CTL_SRC] ? (os2_q && !os3_q) : 1'b1; // [RULE12]
  // Oversample tick: one pulse each baud_q+1 source ticks
  logic [15:0] bdiv_q;
  logic ovs;
  assign ovs = src_tick && (bdiv_q == '0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bdiv_q <= '0;
    end else if (src_tick) begin
      bdiv_q <= (bdiv_q == '0) ? baud_q : bdiv_q - 16'h0001;
    end
  end
  logic wr_data, wr_adsend, rd_data;
  assign wr_data = wr && (addr == REG_DATA);
  assign wr_adsend = wr && (addr == REG_ADSEND);
  assign rd_data = rd && (addr == REG_DATA);
  // Transmit path
  logic tx_empty, tx_full, tx_pop, tx_flush;
  logic [8:0] tx_head;
  unb_st_t tx_st_q;
  logic [3:0] tx_ovs_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  logic tx_pin_q;
  logic tx_nbits_nine;
  // Ninth bit: 1 for address characters, 0 for data
  logic [8:0] tx_in;
  assign tx_in = wr_adsend ? {1'b1, wdata[7:0]} : {1'b0, wdata[7:0]}; // [RULE1] [RULE5] [RULE17]
  // Flush while disabled, but only once the shifter is idle
  assign tx_flush = !ctrl_q[CTL_EN] && (tx_st_q == UNB_IDLE); // [RULE16]
  assign tx_pop = ctrl_q[CTL_EN] && (tx_st_q == UNB_IDLE) && !tx_empty && ovs;

  unb_fifo #(.W(9), .DEPTH(DEPTH)) u_txf (
    .clk(clk),
    .rst_n(rst_n),
    .flush(tx_flush),
    .push((wr_data || wr_adsend) && ctrl_q[CTL_EN]), // [RULE10]
    .wdata(tx_in),
    .pop(tx_pop),
    .rdata(tx_head),
    .empty(tx_empty),
    .full(tx_full)
  );

  assign tx_nbits_nine = ctrl_q[CTL_NINE];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= UNB_IDLE;
      tx_ovs_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_pin_q <= 1'b1;
    end else begin
      case (tx_st_q)
        UNB_IDLE: begin
          tx_pin_q <= 1'b1;
          if (tx_pop) begin
            tx_sh_q <= tx_head;
            tx_ovs_q <= '0;
            tx_pin_q <= 1'b0;
            tx_st_q <= UNB_START;
          end
        end
        UNB_START: begin
          if (ovs) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST) begin
              tx_pin_q <= tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
              tx_bit_q <= 4'h1;
              tx_st_q <= UNB_BITS;
            end
          end
        end
        UNB_BITS: begin
          if (ovs) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST) begin
              if (tx_bit_q == (tx_nbits_nine ? DBITS_9 : DBITS_8)) begin // [RULE4]
                tx_pin_q <= 1'b1;
                tx_st_q <= UNB_STOP;
              end else begin
                tx_pin_q <= tx_sh_q[0];
                tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                tx_bit_q <= tx_bit_q + 4'h1;
              end
            end
          end
        end
        UNB_STOP: begin
          if (ovs) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST) begin
              tx_st_q <= UNB_IDLE;
            end
          end
        end
        default: tx_st_q <= UNB_IDLE;
      endcase
    end
  end

  // Break overrides the shifter, which keeps running underneath
  assign txd = ctrl_q[CTL_BRK] ? 1'b0 : tx_pin_q; // [RULE6] [RULE7]

  logic busy;
  assign busy = !tx_empty || (tx_st_q != UNB_IDLE); // [RULE8] [RULE2]
  // Receive path
  unb_st_t rx_st_q;
  logic [3:0] rx_ovs_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_push, rx_empty, rx_full, rx_frame_err;
  logic [8:0] rx_head, rx_char;
  logic rx_done, rx_sel_q, rx_keep;

  // Align an eight-bit frame to the low bits of the nine-bit shifter
  assign rx_char = ctrl_q[CTL_NINE] ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  assign rx_done = (rx_st_q == UNB_STOP) && ovs && (rx_ovs_q == OVS_MID);
  assign rx_frame_err = rx_done && !rx_s2_q;

  // Address characters are consumed by matching; data kept only when selected
  assign rx_keep = !ctrl_q[CTL_NINE] || (!rx_char[8] && rx_sel_q); // [RULE5]
  assign rx_push = rx_done && rx_s2_q && rx_keep && ctrl_q[CTL_EN];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sel_q <= 1'b0;
    end else if (!ctrl_q[CTL_NINE]) begin
      rx_sel_q <= 1'b0;
    end else if (rx_done && rx_s2_q && rx_char[8]) begin // [RULE17]
      rx_sel_q <= ((rx_char[7:0] & match_mask_q) == (match_addr_q & match_mask_q)); // [RULE3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= UNB_IDLE;
      rx_ovs_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
    end else if (ovs) begin
      case (rx_st_q)
        UNB_IDLE: begin
          if (!rx_s2_q) begin
            rx_ovs_q <= '0;
            rx_st_q <= UNB_START;
          end
        end
        UNB_START: begin
          rx_ovs_q <= rx_ovs_q + 4'h1;
          if (rx_ovs_q == OVS_MID) begin
            rx_ovs_q <= '0;
            rx_bit_q <= '0;
            rx_st_q <= rx_s2_q ? UNB_IDLE : UNB_BITS;
          end
        end
        UNB_BITS: begin
          rx_ovs_q <= rx_ovs_q + 4'h1;
          if (rx_ovs_q == OVS_LAST) begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q + 4'h1 == (ctrl_q[CTL_NINE] ? DBITS_9 : DBITS_8)) begin
              rx_ovs_q <= '0;
              rx_st_q <= UNB_STOP;
            end
          end
        end
        UNB_STOP: begin
          rx_ovs_q <= rx_ovs_q + 4'h1;
          if (rx_ovs_q == OVS_LAST) begin
            rx_st_q <= UNB_IDLE;
          end
        end
        default: rx_st_q <= UNB_IDLE;
      endcase
    end
  end

  unb_fifo #(.W(9), .DEPTH(DEPTH)) u_rxf (
    .clk(clk),
    .rst_n(rst_n),
    .flush(1'b0),
    .push(rx_push),
    .wdata(rx_char),
    .pop(rd_data), // [RULE11]
    .rdata(rx_head),
    .empty(rx_empty),
    .full(rx_full)
  );

  // DMA requests, each gated by its own enable
  assign dma_tx_req = ctrl_q[CTL_DMA_TX] && ctrl_q[CTL_EN] && !tx_full; // [RULE13]
  assign dma_rx_req = ctrl_q[CTL_DMA_RX] && !rx_empty; // [RULE13]

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      match_addr_q <= '0;
      match_mask_q <= MASK_RST;
      baud_q <= BAUD_RST;
      imsk_q <= '0;
    end else if (wr) begin
      case (addr)
        REG_CTRL: ctrl_q <= wdata[CTL_W-1:0]; // [RULE4] [RULE6] [RULE12] [RULE15]
        REG_ADDR: begin
          match_addr_q <= wdata[7:0];
          match_mask_q <= wdata[15:8];
        end
        REG_BAUD: baud_q <= wdata[15:0];
        REG_IMSK: imsk_q <= wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle wins
  logic [IRQ_W-1:0] ev, clr;
  logic busy_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
    end
  end
  always_comb begin
    ev = '0;
    ev[IRQ_RX] = rx_push;
    ev[IRQ_TX_DONE] = busy_q && !busy;
    ev[IRQ_OVR] = rx_push && rx_full;
    ev[IRQ_FRAME] = rx_frame_err;
  end
  assign clr = (wr && addr == REG_RIS) ? wdata[IRQ_W-1:0] : '0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ris_q <= '0;
    end else begin
      ris_q <= (ris_q & ~clr) | ev; // [RULE14]
    end
  end
  assign irq = |(ris_q & imsk_q); // [RULE14]

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (rd) begin
        case (addr)
          REG_DATA: rdata_q <= rx_empty ? '0 : {23'h00_0000, rx_head};
          REG_STAT: begin
            rdata_q[ST_BUSY] <= busy; // [RULE8]
            rdata_q[ST_RX_AVAIL] <= !rx_empty; // [RULE9]
            rdata_q[ST_TX_FULL] <= tx_full; // [RULE10]
            rdata_q[ST_TX_EMPTY] <= tx_empty;
            rdata_q[ST_RX_FULL] <= rx_full;
            rdata_q[ST_SRC] <= ctrl_q[CTL_SRC]; // [RULE12]
          end
          REG_CTRL: rdata_q <= {26'h000_0000, ctrl_q};
          REG_ADDR: rdata_q <= {16'h0000, match_mask_q, match_addr_q};
          REG_BAUD: rdata_q <= {16'h0000, baud_q};
          REG_RIS: rdata_q <= {28'h000_0000, ris_q};
          REG_IMSK: rdata_q <= {28'h000_0000, imsk_q};
          REG_MIS: rdata_q <= {28'h000_0000, ris_q & imsk_q};
          default: rdata_q <= '0;
        endcase
      end
    end
  end
  assign rdata = rdata_q;

  // Checks
  busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
    (tx_st_q != UNB_IDLE) |-> busy) else $error("busy low while shifting");
  brk_line_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
    ctrl_q[CTL_BRK] |-> !txd) else $error("break not driven");
  rx_avail_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
    rx_push |=> !rx_empty) else $error("receive FIFO empty after push");
  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
    (ev[IRQ_RX] && imsk_q[IRQ_RX] && !(wr && addr == REG_IMSK)) |=> irq)
    else $error("masked event gave no interrupt");
  addr_mark_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
    (wr_adsend && ctrl_q[CTL_EN] && !tx_full && tx_empty) |=> tx_head[8])
    else $error("address character not marked");
  dis_flush_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
    (!ctrl_q[CTL_EN] && tx_st_q == UNB_IDLE) |=> tx_empty) else $error("no flush");
  nine_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
    !ctrl_q[CTL_NINE] |=> !rx_sel_q) else $error("match kept in normal mode");
  dma_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
    !ctrl_q[CTL_DMA_RX] |-> !dma_rx_req) else $error("rx dma while disabled");
  rd_pop_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
    (rd_data && !rx_empty && !rx_push) |=> (u_rxf.cnt_q == $past(u_rxf.cnt_q) - 1'b1))
    else $error("read did not pop");
endmodule
`default_nettype wire
